/* ietc_master.sv */
// Remote-mode I2C master bit engine with speed-selected timing
`timescale 1ns/1ps
module ietc_master
(
  // Clock and reset
  input  wire logic     clock,
  input  wire logic     nrst,
  // Engine side of the link
  ietc_master_if.eng    m
);
  typedef enum logic [2:0]
  {
    E_IDLE  = 3'h0,
    E_SHOLD = 3'h1,
    E_BLOW  = 3'h2,
    E_BWAIT = 3'h3,
    E_BHIGH = 3'h4,
    E_PLOW  = 3'h5,
    E_PHIGH = 3'h6,
    E_BUF   = 3'h7
  } ietc_eng_type;

  typedef struct packed
  {
    ietc_eng_type state;
    logic [7:0]   cnt;
    logic         scl_low;
    logic         sda_low;
    logic         rbit;
    logic         rbit_valid;
  } ietc_eng_state_type;

  ietc_eng_state_type s;
  ietc_eng_state_type next_s;
  logic [7:0]         low_c;
  logic [7:0]         high_c;
  logic [7:0]         buf_c;

  // ==========================================================
  // Timing set
  always_comb
  begin
    unique case (m.speed)
      ietc_pkg::SPD_SM:
      begin
        low_c  = 8'(ietc_pkg::LOW_SM_CYC - 1);
        high_c = 8'(ietc_pkg::HIGH_SM_CYC - 1);
        buf_c  = 8'(ietc_pkg::BUF_SM_CYC - 1);
      end
      ietc_pkg::SPD_FM:
      begin
        low_c  = 8'(ietc_pkg::LOW_FM_CYC - 1);
        high_c = 8'(ietc_pkg::HIGH_FM_CYC - 1);
        buf_c  = 8'(ietc_pkg::BUF_FM_CYC - 1);
      end
      default:
      begin
        low_c  = 8'(ietc_pkg::LOW_FMP_CYC - 1);
        high_c = 8'(ietc_pkg::HIGH_FMP_CYC - 1);
        buf_c  = 8'(ietc_pkg::BUF_FMP_CYC - 1);
      end
    endcase
  end

  // ==========================================================
  // Bit sequencer
  always_comb
  begin
    next_s = s;
    next_s.rbit_valid = 1'b0;
    if (s.cnt != 8'h00)
      next_s.cnt = s.cnt - 8'h01;
    unique case (s.state)
      E_IDLE:
        if (m.cmd_valid)
        begin
          if (m.cmd == ietc_pkg::CMD_START)
          begin
            next_s.sda_low = 1'b1;
            next_s.cnt     = high_c;
            next_s.state   = E_SHOLD;
          end
          else if (m.cmd == ietc_pkg::CMD_BIT)
          begin
            next_s.scl_low = 1'b1;
            next_s.sda_low = ~m.wbit;
            next_s.cnt     = low_c;
            next_s.state   = E_BLOW;
          end
          else if (m.cmd == ietc_pkg::CMD_STOP)
          begin
            next_s.scl_low = 1'b1;
            next_s.sda_low = 1'b1;
            next_s.cnt     = low_c;
            next_s.state   = E_PLOW;
          end
        end
      E_SHOLD:
        if (s.cnt == 8'h00)
        begin
          next_s.scl_low = 1'b1;
          next_s.state   = E_IDLE;
        end
      E_BLOW:
        if (s.cnt == 8'h00)
        begin
          next_s.scl_low = 1'b0;
          next_s.state   = E_BWAIT;
        end
      E_BWAIT:
        if (m.scl_in)
        begin
          next_s.cnt   = high_c;
          next_s.state = E_BHIGH;
        end
      E_BHIGH:
        if (s.cnt == 8'h00)
        begin
          next_s.rbit       = m.sda_in;
          next_s.rbit_valid = 1'b1;
          next_s.scl_low    = 1'b1;
          next_s.state      = E_IDLE;
        end
      E_PLOW:
        if (s.cnt == 8'h00)
        begin
          next_s.scl_low = 1'b0;
          next_s.cnt     = high_c;
          next_s.state   = E_PHIGH;
        end
      E_PHIGH:
        if (s.cnt == 8'h00)
        begin
          next_s.sda_low = 1'b0;
          next_s.cnt     = buf_c;
          next_s.state   = E_BUF;
        end
      E_BUF:
        if (s.cnt == 8'h00)
          next_s.state = E_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      s <= '0;
    else
      s <= next_s;
  end

  assign m.cmd_ready  = (s.state == E_IDLE);
  assign m.rbit       = s.rbit;
  assign m.rbit_valid = s.rbit_valid;
  assign m.scl_low    = s.scl_low;
  assign m.sda_low    = s.sda_low;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  low_phase_a: assert property ((s.state == E_BLOW) && ($past(s.state) != E_BLOW) |-> s.scl_low [*8])
    else $error("SCL low phase too short");
  high_phase_a: assert property ($rose(s.state == E_BHIGH) |-> (s.state == E_BHIGH) [*8])
    else $error("SCL high phase too short");
  bus_free_a: assert property ($rose(s.state == E_BUF) |-> (!s.sda_low && !s.scl_low) [*8])
    else $error("Bus free time too short");
endmodule

/* ietc_master_if.sv */
// Link between the control top and the master bit engine
`timescale 1ns/1ps
interface ietc_master_if;
  logic       cmd_valid;
  logic       cmd_ready;
  logic [1:0] cmd;
  logic       wbit;
  logic       rbit;
  logic       rbit_valid;
  logic [1:0] speed;
  logic       scl_in;
  logic       sda_in;
  logic       scl_low;
  logic       sda_low;
  modport ctrl (output cmd_valid, cmd, wbit, speed, scl_in, sda_in,
                input  cmd_ready, rbit, rbit_valid, scl_low, sda_low);
  modport eng  (input  cmd_valid, cmd, wbit, speed, scl_in, sda_in,
                output cmd_ready, rbit, rbit_valid, scl_low, sda_low);
endinterface

/* ietc_partner.sv */
// Far-side model: host master on the local bus, stretching slave on the remote bus
`timescale 1ns/1ps
module ietc_partner
(
  // Clock
  input  wire logic       clock,
  // Bus wires
  input  wire logic       scl,
  // Slave behaviour
  input  wire logic       slave_bit,
  input  wire logic [3:0] stretch,
  // Pin releases, high = released to the pull-up
  output logic            scl_rel,
  output logic            sda_rel
);
  logic host_scl = 1'b1;
  logic hold_scl = 1'b1;
  logic scl_q    = 1'b1;
  int   cnt      = 0;
  assign scl_rel = host_scl & hold_scl;
  assign sda_rel = slave_bit;
  // Slave holds SCL low a few cycles after each falling edge, seen where the wire is settled
  always @(negedge clock)
  begin
    if (scl_q && !scl)
      cnt = stretch;
    hold_scl <= (cnt == 0);
    if (cnt > 0)
      cnt = cnt - 1;
    scl_q = scl;
  end
  task automatic host_set(input logic v);
    host_scl = v;
  endtask
  // Host clock pulses at up to 2 MHz, waiting out any stretch
  task automatic host_pulses(input int n, input int lo, input int hi);
    for (int i = 0; i < n; i++)
    begin
      host_scl = 1'b0;
      repeat (lo) @(posedge clock);
      #1 host_scl = 1'b1;
      for (int w = 0; w < 1000 && scl !== 1'b1; w++)
      begin
        @(posedge clock);
        #1;
      end
      repeat (hi) @(posedge clock);
      #1;
    end
  endtask
endmodule

/* ietc_pkg.sv */
// Shared constants for the extender timing and control block
package ietc_pkg;
  // ==========================================================
  // Clock
  localparam int CLK_NS = 50;
  // ==========================================================
  // Times in ns, except T_REM_RST_MS in ms and T_STUCK_US in us
  localparam int T_ON_LOW_NS   = 1000;
  localparam int T_READY_NS    = 65000;
  localparam int T_IDLE_NS     = 70000;
  localparam int T_GAP_NS      = 1000;
  localparam int T_REM_RST_MS  = 180;
  localparam int T_STUCK_US    = 31500;
  localparam int T_PER_FMP_NS  = 1000;
  localparam int T_PER_FM_NS   = 2500;
  localparam int T_PER_SM_NS   = 10000;
  localparam int T_LOW_FMP_NS  = 600;
  localparam int T_LOW_FM_NS   = 1500;
  localparam int T_LOW_SM_NS   = 5800;
  localparam int T_BUF_FMP_NS  = 600;
  localparam int T_BUF_FM_NS   = 1500;
  localparam int T_BUF_SM_NS   = 5000;
  // ==========================================================
  // Cycle counts, least times rounded up
  localparam int ON_LOW_CYC    = (T_ON_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int READY_CYC     = T_READY_NS / CLK_NS;
  localparam int IDLE_CYC      = (T_IDLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYC       = (T_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int REM_RST_CYC   = T_REM_RST_MS * (1000000 / CLK_NS);
  localparam int STUCK_CYC     = T_STUCK_US * 1000 / CLK_NS;
  localparam int PER_FMP_CYC   = (T_PER_FMP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PER_FM_CYC    = (T_PER_FM_NS + CLK_NS - 1) / CLK_NS;
  localparam int PER_SM_CYC    = (T_PER_SM_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOW_FMP_CYC   = (T_LOW_FMP_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOW_FM_CYC    = (T_LOW_FM_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOW_SM_CYC    = (T_LOW_SM_NS + CLK_NS - 1) / CLK_NS;
  localparam int HIGH_FMP_CYC  = PER_FMP_CYC - LOW_FMP_CYC;
  localparam int HIGH_FM_CYC   = PER_FM_CYC - LOW_FM_CYC;
  localparam int HIGH_SM_CYC   = PER_SM_CYC - LOW_SM_CYC;
  localparam int BUF_FMP_CYC   = (T_BUF_FMP_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUF_FM_CYC    = (T_BUF_FM_NS + CLK_NS - 1) / CLK_NS;
  localparam int BUF_SM_CYC    = (T_BUF_SM_NS + CLK_NS - 1) / CLK_NS;
  // ==========================================================
  // Speed codes {rate_select_a, rate_select_b}
  localparam logic [1:0] SPD_SM  = 2'h0;
  localparam logic [1:0] SPD_FM  = 2'h1;
  // Master commands
  localparam logic [1:0] CMD_START = 2'h0;
  localparam logic [1:0] CMD_BIT   = 2'h1;
  localparam logic [1:0] CMD_STOP  = 2'h2;
endpackage

/* ietc_top.sv */
// Enable, ready, idle, timeout and throughput control of the extender node
`timescale 1ns/1ps
module ietc_top
#(
  parameter int REM_RST_CYC = ietc_pkg::REM_RST_CYC,
  parameter int STUCK_CYC   = ietc_pkg::STUCK_CYC
)
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // Control pins
  input  wire logic       enable,
  input  wire logic       remote_mode,
  input  wire logic       rate_select_a,
  input  wire logic       rate_select_b,
  // Status
  output logic            ready_n,
  output logic            bus_idle,
  output logic            stuck_bus,
  output logic            far_reset,
  // I2C pins
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe_n,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  // Remote master commands
  input  wire logic       mst_cmd_valid,
  input  wire logic [1:0] mst_cmd,
  input  wire logic       mst_wbit,
  output logic            mst_cmd_ready,
  output logic            mst_rbit,
  output logic            mst_rbit_valid
);
  typedef enum logic [1:0]
  {
    M_OFF  = 2'h0,
    M_WAIT = 2'h1,
    M_RUN  = 2'h2
  } ietc_mode_type;

  typedef struct packed
  {
    logic [1:0]    en_sy;
    logic [1:0]    scl_sy;
    logic [1:0]    sda_sy;
    logic [1:0]    rem_sy;
    logic [1:0]    sa_sy;
    logic [1:0]    sb_sy;
    ietc_mode_type mode;
    logic [21:0]   en_low_cnt;
    logic [10:0]   ready_cnt;
    logic [10:0]   idle_cnt;
    logic [19:0]   stuck_cnt;
    logic [4:0]    gap;
    logic [1:0]    speed;
    logic          ready;
    logic          idle;
    logic          stuck;
    logic          far_rst;
    logic          scl_prev;
    logic          stretch;
  } ietc_top_state_type;

  ietc_top_state_type s;
  ietc_top_state_type next_s;
  ietc_master_if      mif ();
  logic               en_i;
  logic               scl_i;
  logic               remote;

  assign en_i   = s.en_sy[1];
  assign scl_i  = s.scl_sy[1];
  assign remote = s.rem_sy[1];

  // ==========================================================
  // Control state
  always_comb
  begin
    next_s = s;
    next_s.en_sy  = {s.en_sy[0], enable};
    next_s.scl_sy = {s.scl_sy[0], scl_in};
    next_s.sda_sy = {s.sda_sy[0], sda_in};
    next_s.rem_sy = {s.rem_sy[0], remote_mode};
    next_s.sa_sy  = {s.sa_sy[0], rate_select_a};
    next_s.sb_sy  = {s.sb_sy[0], rate_select_b};
    next_s.scl_prev = scl_i;
    // Enable low time
    if (en_i)
      next_s.en_low_cnt = 22'h000000;
    else if (s.en_low_cnt < 22'(REM_RST_CYC))
      next_s.en_low_cnt = s.en_low_cnt + 22'h000001;
    next_s.far_rst = !remote && !en_i && (s.en_low_cnt >= 22'(REM_RST_CYC - 1));
    unique case (s.mode)
      M_OFF:
        if (en_i)
        begin
          next_s.speed     = {s.sa_sy[1], s.sb_sy[1]};
          next_s.ready_cnt = 11'h000;
          next_s.mode      = M_WAIT;
        end
      M_WAIT:
        if (s.ready_cnt != 11'(ietc_pkg::READY_CYC - 1))
          next_s.ready_cnt = s.ready_cnt + 11'h001;
        else if (remote || s.idle)
        begin
          next_s.ready = 1'b1;
          next_s.mode  = M_RUN;
        end
      M_RUN:
        next_s.mode = M_RUN;
      default:
        next_s.mode = M_OFF;
    endcase
    if (!en_i && (s.en_low_cnt == 22'(ietc_pkg::ON_LOW_CYC - 1)))
    begin
      next_s.mode  = M_OFF;
      next_s.ready = 1'b0;
    end
    // Bus idle detection
    if (!scl_i)
    begin
      next_s.idle_cnt = 11'h000;
      next_s.idle     = 1'b0;
    end
    else if (s.idle_cnt != 11'(ietc_pkg::IDLE_CYC - 1))
      next_s.idle_cnt = s.idle_cnt + 11'h001;
    else
      next_s.idle = 1'b1;
    // Stuck SCL detection
    if (scl_i || remote)
    begin
      next_s.stuck_cnt = 20'h00000;
      next_s.stuck     = 1'b0;
    end
    else if (s.stuck_cnt != 20'(STUCK_CYC - 1))
      next_s.stuck_cnt = s.stuck_cnt + 20'h00001;
    else
      next_s.stuck = 1'b1;
    // Throughput limit: no new SCL high before one link bit time
    if (!remote && scl_i && !s.scl_prev)
      next_s.gap = 5'(ietc_pkg::GAP_CYC - 1);
    else if (s.gap != 5'h00)
      next_s.gap = s.gap - 5'h01;
    next_s.stretch = !remote && !s.stuck && (s.mode == M_RUN) && (s.gap > 5'h01)
                     && (!scl_i || s.stretch);
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      s <= '0;
    else
      s <= next_s;
  end

  // ==========================================================
  // Remote master
  assign mif.cmd_valid = mst_cmd_valid && remote && (s.mode == M_RUN);
  assign mif.cmd       = mst_cmd;
  assign mif.wbit      = mst_wbit;
  assign mif.speed     = s.speed;
  assign mif.scl_in    = scl_i;
  assign mif.sda_in    = s.sda_sy[1];

  ietc_master u_master
  (
    .clock (clock),
    .nrst  (nrst),
    .m     (mif.eng)
  );

  // ==========================================================
  // Outputs
  assign ready_n        = !s.ready;
  assign bus_idle       = s.idle;
  assign stuck_bus      = s.stuck;
  assign far_reset      = s.far_rst;
  assign scl_out        = 1'b0;
  assign sda_out        = 1'b0;
  assign scl_oe_n       = !(s.stretch || (remote && mif.scl_low));
  assign sda_oe_n       = !(remote && mif.sda_low);
  assign mst_cmd_ready  = mif.cmd_ready && remote && (s.mode == M_RUN);
  assign mst_rbit       = mif.rbit;
  assign mst_rbit_valid = mif.rbit_valid;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  valid_reset_a: assert property (!en_i && (s.en_low_cnt == 22'(ietc_pkg::ON_LOW_CYC - 1)) |=> (s.mode == M_OFF) && !s.ready)
    else $error("Valid enable pulse did not reset");
  ready_delay_a: assert property ($rose(s.ready) |-> $past(s.ready_cnt) == 11'(ietc_pkg::READY_CYC - 1)
                                  && ($past(s.idle) || $past(remote)))
    else $error("Ready asserted at wrong time");
  far_reset_a: assert property ($rose(s.far_rst) |-> $past(s.en_low_cnt) >= 22'(REM_RST_CYC - 1) && !$past(en_i))
    else $error("Far reset too early");
  stuck_time_a: assert property ($rose(s.stuck) |-> $past(s.stuck_cnt) == 20'(STUCK_CYC - 1) && !$past(scl_i))
    else $error("Stuck flag at wrong time");
  idle_time_a: assert property ($rose(s.idle) |-> $past(s.idle_cnt) == 11'(ietc_pkg::IDLE_CYC - 1))
    else $error("Idle flagged too early");
  idle_clear_a: assert property (!scl_i |=> !s.idle)
    else $error("Idle kept while SCL low");
  stretch_gap_a: assert property (!remote && scl_i && !s.scl_prev && !$past(remote) |=> s.gap == 5'(ietc_pkg::GAP_CYC - 1))
    else $error("Throughput gap not started");
  speed_hold_a: assert property ((s.mode != M_OFF) && ($past(s.mode) != M_OFF) |-> $stable(s.speed))
    else $error("Speed changed after sampling");
endmodule

/* tb.sv */
// Self-checking bench for the extender timing and control block
`timescale 1ns/1ps
module tb;
  localparam int RST_CYC = 200;
  localparam int STK_CYC = 300;
  logic       clock         = 1'b0;
  logic       nrst          = 1'b0;
  logic       enable        = 1'b0;
  logic       remote_mode   = 1'b0;
  logic       rate_select_a = 1'b0;
  logic       rate_select_b = 1'b0;
  logic       mst_cmd_valid = 1'b0;
  logic [1:0] mst_cmd       = 2'h0;
  logic       mst_wbit      = 1'b0;
  logic       slave_bit     = 1'b1;
  logic [3:0] stretch       = 4'h0;
  logic       ready_n, bus_idle, stuck_bus, far_reset, scl_w, sda_w, scl_rel, sda_rel;
  logic       scl_out, scl_oe_n, sda_out, sda_oe_n, mst_cmd_ready, mst_rbit, mst_rbit_valid, w;
  logic       scl_p = 1'b1, sda_p = 1'b1, seen_fall = 1'b0, seen_stop = 1'b0, saw_stretch = 1'b0;
  int         seed = 32'hc4546c1a;
  int         n_fail = 0, compares = 0, cyc = 0, t0 = 0;
  int         since_fall = 0, since_stop = 0, min_per = 99999, min_buf = 99999;
  assign scl_w = (scl_oe_n ? 1'b1 : scl_out) & scl_rel;
  assign sda_w = (sda_oe_n ? 1'b1 : sda_out) & sda_rel;
  always #25 clock = ~clock;
  ietc_top #(.REM_RST_CYC(RST_CYC), .STUCK_CYC(STK_CYC)) i_dut
  (
    .clock(clock), .nrst(nrst), .enable(enable), .remote_mode(remote_mode),
    .rate_select_a(rate_select_a), .rate_select_b(rate_select_b), .ready_n(ready_n),
    .bus_idle(bus_idle), .stuck_bus(stuck_bus), .far_reset(far_reset), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .mst_cmd_valid(mst_cmd_valid), .mst_cmd(mst_cmd), .mst_wbit(mst_wbit),
    .mst_cmd_ready(mst_cmd_ready), .mst_rbit(mst_rbit), .mst_rbit_valid(mst_rbit_valid)
  );
  ietc_partner i_partner
  (
    .clock(clock), .scl(scl_w), .slave_bit(slave_bit), .stretch(stretch),
    .scl_rel(scl_rel), .sda_rel(sda_rel)
  );
  // ==========================================================
  // Wire timing monitors and time limit, sampled off the launching edge
  always @(negedge clock)
  begin
    cyc++;
    since_fall++;
    since_stop++;
    if (!remote_mode && scl_oe_n === 1'b0)
      saw_stretch = 1'b1;
    if (scl_p && !scl_w && seen_fall && since_fall < min_per)
      min_per = since_fall;
    if (scl_p && !scl_w)
      {seen_fall, since_fall} = {1'b1, 32'h0};
    if (scl_w && scl_p && sda_p && !sda_w && seen_stop && since_stop < min_buf)
      min_buf = since_stop;
    if (scl_w && scl_p && !sda_p && sda_w)
      {seen_stop, since_stop} = {1'b1, 32'h0};
    {scl_p, sda_p} = {scl_w, sda_w};
    if (cyc == 60000)
    begin
      n_fail++;
      test_done();
    end
  end
  // ==========================================================
  // Helpers
  function automatic int per_cyc(input int s);
    return s == 2 ? ietc_pkg::PER_FMP_CYC : s == 1 ? ietc_pkg::PER_FM_CYC : ietc_pkg::PER_SM_CYC;
  endfunction
  function automatic int buf_cyc(input int s);
    return s == 2 ? ietc_pkg::BUF_FMP_CYC : s == 1 ? ietc_pkg::BUF_FM_CYC : ietc_pkg::BUF_SM_CYC;
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s: got %b want %b", $time, what, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi, input string what);
    compares++;
    if (got < lo || got > hi)
    begin
      n_fail++;
      $display("[FAIL] %0t %s: got %0d want %0d..%0d", $time, what, got, lo, hi);
    end
  endtask
  // One master command, held until taken; BIT waits for its read bit
  task automatic mst_do(input logic [1:0] c, input logic wb);
    int i;
    step(1);
    {mst_cmd_valid, mst_cmd, mst_wbit} = {1'b1, c, wb};
    for (i = 0; i < 3000 && mst_cmd_ready !== 1'b1; i++)
      @(negedge clock);
    chk_rng(i, 0, 2999, "command not taken");
    step(1);
    mst_cmd_valid = 1'b0;
    for (i = 0; c == ietc_pkg::CMD_BIT && i < 3000 && mst_rbit_valid !== 1'b1; i++)
      @(negedge clock);
    if (c == ietc_pkg::CMD_BIT)
    begin
      chk_rng(i, 0, 2999, "read bit late");
      chk_bit(mst_rbit, wb & slave_bit, "read bit");
    end
  endtask
  task automatic test_done;
    if (n_fail == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    step(3);
    nrst = 1'b1;
    step(ietc_pkg::IDLE_CYC - 5);
    chk_bit(bus_idle, 1'b0, "idle early");
    step(20);
    chk_bit(bus_idle, 1'b1, "idle late");
    enable = 1'b1;
    step(ietc_pkg::READY_CYC - 10);
    chk_bit(ready_n, 1'b1, "ready early");
    step(30);
    chk_bit(ready_n, 1'b0, "ready late");
    chk_bit(mst_cmd_ready, 1'b0, "local command refused");
    enable = 1'b0;
    step(ietc_pkg::ON_LOW_CYC - 5);
    enable = 1'b1;
    step(30);
    chk_bit(ready_n, 1'b0, "short pulse");
    enable = 1'b0;
    step(ietc_pkg::ON_LOW_CYC + 5);
    chk_bit(ready_n, 1'b1, "valid pulse");
    step(RST_CYC - ietc_pkg::ON_LOW_CYC - 15);
    chk_bit(far_reset, 1'b0, "far reset early");
    step(20);
    chk_bit(far_reset, 1'b1, "far reset late");
    enable = 1'b1;
    step(5);
    chk_bit(far_reset, 1'b0, "far reset clear");
    step(ietc_pkg::READY_CYC + 20);
    i_partner.host_set(1'b0);
    step(STK_CYC - 10);
    chk_bit(stuck_bus, 1'b0, "stuck early");
    chk_bit(bus_idle, 1'b0, "idle while low");
    step(20);
    chk_bit(stuck_bus, 1'b1, "stuck late");
    i_partner.host_set(1'b1);
    step(5);
    chk_bit(stuck_bus, 1'b0, "stuck clear");
    step(ietc_pkg::IDLE_CYC);
    t0 = cyc;
    i_partner.host_pulses(16, 5, 5);
    chk_rng(cyc - t0, 15 * ietc_pkg::GAP_CYC, 9999, "host throughput");
    chk_bit(saw_stretch, 1'b1, "local stretch");
    for (int s = 0; s < 3; s++)
    begin
      {remote_mode, enable, rate_select_a, rate_select_b} = {2'b10, s == 2, s == 1};
      step(ietc_pkg::ON_LOW_CYC + 5);
      enable = 1'b1;
      step(10);
      {rate_select_a, rate_select_b} = {s != 2, s != 1};
      {seen_fall, seen_stop, min_per, min_buf} = {2'b00, 32'd99999, 32'd99999};
      stretch = 4'($random(seed));
      mst_do(ietc_pkg::CMD_START, 1'b0);
      for (int b = 0; b < 9; b++)
      begin
        w = 1'($random(seed));
        slave_bit = 1'($random(seed));
        mst_do(ietc_pkg::CMD_BIT, w);
      end
      slave_bit = 1'b1;
      mst_do(ietc_pkg::CMD_STOP, 1'b0);
      mst_do(ietc_pkg::CMD_START, 1'b0);
      mst_do(ietc_pkg::CMD_STOP, 1'b0);
      // Reserved command code must leave both wires released
      mst_do(2'h3, 1'b1);
      step(5);
      chk_bit(scl_oe_n & sda_oe_n, 1'b1, "reserved command ignored");
      chk_rng(min_per, per_cyc(s), per_cyc(s) + 20, "scl period");
      chk_rng(min_buf, buf_cyc(s), buf_cyc(s) + 20, "bus free");
    end
    test_done();
  end
endmodule
